// ==== hw/sdci_pkg.sv ====
// shared constants for the serial dac command link
package sdci_pkg;
    localparam int SHIFT_W     = 32;
    localparam int WORD_W      = 24;
    localparam int CMD_W       = 4;
    localparam int DATA_W      = 16;
    localparam int CMD_MSB     = 23;
    localparam int DATA_MSB    = 15;
    localparam logic [3:0] CMD_WRITE   = 4'h0;
    localparam logic [3:0] CMD_UPDATE  = 4'h1;
    localparam logic [3:0] CMD_WR_UPD  = 4'h3;
    localparam logic [3:0] CMD_PWRDN   = 4'h4;
    localparam logic [3:0] CMD_NOP     = 4'hf;
    localparam logic [15:0] CODE_ZERO  = 16'h0000;
    localparam logic [15:0] CODE_MID   = 16'h8000;
    localparam int CLK_HZ       = 40000000;
    localparam int PWRUP_5V_NS  = 12000;
    localparam int PWRUP_3V_NS  = 30000;
    localparam int PWRUP_5V_CYC = (PWRUP_5V_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int PWRUP_3V_CYC = (PWRUP_3V_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int LINK_DIV     = 4;
    typedef enum logic [1:0] {SDCI_IDLE, SDCI_SHIFT, SDCI_END} sdci_host_state_t;
endpackage

// ==== hw/sdci_link_if.sv ====
// three-wire link between the host and a dac
interface sdci_link_if;
    logic serial_clk;
    logic serial_word_in;
    logic select_load_strobe_n;
    logic serial_chain_out;
    modport dac  (input serial_clk, input serial_word_in, input select_load_strobe_n,
                  output serial_chain_out);
    modport host (output serial_clk, output serial_word_in, output select_load_strobe_n,
                  input serial_chain_out);
endinterface

// ==== hw/sdci_dac.sv ====
// dac end: serial shift register, command decode, input and dac registers
// Contract
// - sample data on rising serial clock
// - chain out delayed 32 edges, falling
// - frames of 24 or 32 bits
// - clear forces registers to reset code
// - shift while strobe low, execute at rise
// - host sends command, four spare, data
// - data msb first, low bits ignored
// - execute the last 24 shifted bits
// - decode write, update, both, powerdown, nop
// - write loads input register only
// - update copies input to dac, powers up
// - host prefixes eight spare bits
// - chain words, first aims last device
// - powerdown keeps both registers
// - any update leaves powerdown
// - flag output not ready after power-up
// - update pin fall copies when strobe high
// - deferred update applied if pin still low
// - short pulse powers up, no copy
// - low update pin powers up, blocks powerdown
// - power-on to zero or midscale
module sdci_dac #(
    parameter bit MIDSCALE   = 1'b0,
    parameter int RES_BITS   = 16,
    parameter int PWRUP_CYC  = sdci_pkg::PWRUP_5V_CYC
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    sdci_link_if.dac         link,
    input  wire logic        async_clear_n_in,
    input  wire logic        async_update_n_in,
    output logic [15:0]      dac_code_out,
    output logic [15:0]      input_code_out,
    output logic             powered_down_out,
    output logic             output_ready_out
);
    localparam logic [15:0] RST_CODE = MIDSCALE ? sdci_pkg::CODE_MID : sdci_pkg::CODE_ZERO;
    localparam logic [15:0] RES_MASK = 16'hffff << (sdci_pkg::DATA_W - RES_BITS);

    // two-flop synchronisers; stage one is read only by stage two
    logic [1:0] clk_s;
    logic [1:0] sdi_s;
    logic [1:0] cs_s;
    logic [1:0] clr_s;
    logic [1:0] ld_s;
    logic       clk_d;
    logic       cs_d;
    logic       ld_d;

    // true for one cycle when a synchronised level has just gone high or low
    function automatic logic went_high(input logic now_lvl, input logic was_lvl);
        return now_lvl && !was_lvl;
    endfunction

    function automatic logic went_low(input logic now_lvl, input logic was_lvl);
        return !now_lvl && was_lvl;
    endfunction

    // strobe resets to its idle high level so no false frame follows reset
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clk_s <= 2'h0;
            sdi_s <= 2'h0;
            cs_s  <= 2'h3;
        end else begin
            clk_s <= {clk_s[0], link.serial_clk};
            sdi_s <= {sdi_s[0], link.serial_word_in};
            cs_s  <= {cs_s[0], link.select_load_strobe_n};
        end
    end

    // clear and update pins idle high
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clr_s <= 2'h3;
            ld_s  <= 2'h3;
        end else begin
            clr_s <= {clr_s[0], async_clear_n_in};
            ld_s  <= {ld_s[0], async_update_n_in};
        end
    end

    // one-cycle history of the synchronised levels for edge detection
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clk_d <= 1'b0;
            cs_d  <= 1'b1;
            ld_d  <= 1'b1;
        end else begin
            clk_d <= clk_s[1];
            cs_d  <= cs_s[1];
            ld_d  <= ld_s[1];
        end
    end

    logic sck_rise, sck_fall, cs_low, cs_rise, ld_low, ld_fall, clr_low;
    assign cs_low   = !cs_s[1];
    assign sck_rise = went_high(clk_s[1], clk_d) && cs_low;
    assign sck_fall = went_low(clk_s[1], clk_d);
    assign cs_rise  = went_high(cs_s[1], cs_d);
    assign ld_low   = !ld_s[1];
    assign ld_fall  = went_low(ld_s[1], ld_d);
    assign clr_low  = !clr_s[1];

    logic [sdci_pkg::SHIFT_W-1:0] shifter;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            shifter <= '0;
        else if (sck_rise)
            shifter <= {shifter[sdci_pkg::SHIFT_W-2:0], sdi_s[1]};
    end

    // chain out changes on the falling edge after the 32nd rise
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            link.serial_chain_out <= 1'b0;
        else if (sck_fall)
            link.serial_chain_out <= shifter[sdci_pkg::SHIFT_W-1];
    end

    // only the last 24 bits matter, so 24- and 32-bit frames decode alike
    logic [3:0]  cmd;
    logic [15:0] data;
    assign cmd  = shifter[sdci_pkg::CMD_MSB -: sdci_pkg::CMD_W];
    assign data = shifter[sdci_pkg::DATA_MSB -: sdci_pkg::DATA_W] & RES_MASK;

    logic do_write, do_update, do_pwrdn, pin_update;
    always_comb begin
        do_write  = 1'b0;
        do_update = 1'b0;
        do_pwrdn  = 1'b0;
        if (cs_rise) begin
            case (cmd)
                sdci_pkg::CMD_WRITE:  do_write = 1'b1;
                sdci_pkg::CMD_UPDATE: do_update = 1'b1;
                sdci_pkg::CMD_WR_UPD: begin
                    do_write  = 1'b1;
                    do_update = 1'b1;
                end
                sdci_pkg::CMD_PWRDN:  do_pwrdn = !ld_low;
                default: ;
            endcase
        end
    end
    // pin low at strobe rise applies deferred update; fall with strobe high acts now
    assign pin_update = (ld_fall && !cs_low && !cs_rise) || (cs_rise && ld_low);

    logic [15:0] next_dac;
    always_comb begin
        next_dac = dac_code_out;
        if (do_update || pin_update)
            next_dac = do_write ? data : input_code_out;
    end

    // clear is level-held, so both registers follow it while low
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            input_code_out <= RST_CODE;
            dac_code_out   <= RST_CODE;
        end else if (clr_low) begin
            input_code_out <= RST_CODE;
            dac_code_out   <= RST_CODE;
        end else begin
            if (do_write)
                input_code_out <= data;
            dac_code_out <= next_dac;
        end
    end

    // any update, by pin or by command, wins over a power-down in the same cycle
    logic power_up;
    assign power_up = do_update || pin_update || ld_low;

    logic next_powered_down;
    always_comb begin
        next_powered_down = powered_down_out;
        if (power_up)
            next_powered_down = 1'b0;
        else if (do_pwrdn)
            next_powered_down = 1'b1;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            powered_down_out <= 1'b0;
        else
            powered_down_out <= next_powered_down;
    end

    // not-ready window after leaving power-down; its length depends on the supply
    localparam int CNT_W = $clog2(PWRUP_CYC + 1);
    logic [CNT_W-1:0] pwr_cnt;
    logic [CNT_W-1:0] next_pwr_cnt;
    always_comb begin
        next_pwr_cnt = pwr_cnt;
        if (powered_down_out && power_up)
            next_pwr_cnt = CNT_W'(PWRUP_CYC);
        else if (pwr_cnt != '0)
            next_pwr_cnt = pwr_cnt - 1'b1;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            pwr_cnt <= '0;
        else
            pwr_cnt <= next_pwr_cnt;
    end

    // taken from the next state so ready moves in the same cycle as the state itself
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            output_ready_out <= 1'b1;
        else
            output_ready_out <= !next_powered_down && (next_pwr_cnt == '0);
    end
endmodule

// ==== hw/sdci_host.sv ====
// host end: frames a 24- or 32-bit word onto the three-wire link
module sdci_host #(
    parameter int DIV = sdci_pkg::LINK_DIV
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    sdci_link_if.host        link,
    input  wire logic        req_valid_in,
    input  wire logic        req_long_in,
    input  wire logic [3:0]  req_cmd_in,
    input  wire logic [15:0] req_data_in,
    output logic             req_ready_out,
    output logic [31:0]      chain_rx_out,
    output logic             done_out
);
    sdci_pkg::sdci_host_state_t state;
    logic [31:0] tx;
    logic [5:0]  bits_left;
    logic [$clog2(DIV)-1:0] div_cnt;
    logic        phase_end;
    logic [1:0]  rx_s;

    assign phase_end     = (div_cnt == ($clog2(DIV))'(DIV - 1));
    assign req_ready_out = (state == sdci_pkg::SDCI_IDLE);
    // data moves only with the falling link clock, so it stands across every rise
    assign link.serial_word_in = tx[31];

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            rx_s <= 2'h0;
        else
            rx_s <= {rx_s[0], link.serial_chain_out};
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            div_cnt <= '0;
        else if (state == sdci_pkg::SDCI_IDLE || phase_end)
            div_cnt <= '0;
        else
            div_cnt <= div_cnt + 1'b1;
    end

    // each bit: clock low for DIV cycles, then high for DIV cycles
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state                     <= sdci_pkg::SDCI_IDLE;
            tx                        <= '0;
            bits_left                 <= '0;
            link.serial_clk           <= 1'b0;
            link.select_load_strobe_n <= 1'b1;
            chain_rx_out              <= '0;
            done_out                  <= 1'b0;
        end else begin
            done_out <= 1'b0;
            case (state)
                sdci_pkg::SDCI_IDLE: begin
                    if (req_valid_in) begin
                        // command, four spare bits, data; long frame adds eight spare
                        tx <= {8'h00, req_cmd_in, 4'h0, req_data_in} <<
                              (req_long_in ? 0 : sdci_pkg::SHIFT_W - sdci_pkg::WORD_W);
                        bits_left <= req_long_in ? 6'(sdci_pkg::SHIFT_W) :
                                                   6'(sdci_pkg::WORD_W);
                        link.select_load_strobe_n <= 1'b0;
                        state <= sdci_pkg::SDCI_SHIFT;
                    end
                end
                sdci_pkg::SDCI_SHIFT: begin
                    if (phase_end) begin
                        if (!link.serial_clk) begin
                            link.serial_clk <= 1'b1;
                            bits_left       <= bits_left - 6'h01;
                        end else begin
                            // chain out settled after the previous fall; take it before it moves
                            link.serial_clk <= 1'b0;
                            tx              <= {tx[30:0], 1'b0};
                            chain_rx_out    <= {chain_rx_out[30:0], rx_s[1]};
                            if (bits_left == 6'h00)
                                state <= sdci_pkg::SDCI_END;
                        end
                    end
                end
                sdci_pkg::SDCI_END: begin
                    if (phase_end) begin
                        link.select_load_strobe_n <= 1'b1;
                        done_out <= 1'b1;
                        state <= sdci_pkg::SDCI_IDLE;
                    end
                end
                default: state <= sdci_pkg::SDCI_IDLE;
            endcase
        end
    end
endmodule

// ==== bench/sdci_link_monitor.sv ====
// checker on the link wires between the host end and the dac end
module sdci_link_monitor (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic serial_clk,
    input wire logic serial_word_in,
    input wire logic select_load_strobe_n,
    input wire logic serial_chain_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk_q;
    logic [5:0] edges;
    logic [3:0] age;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clk_q <= 1'h0;
            edges <= 6'h00;
            age   <= 4'hf;
        end else begin
            clk_q <= serial_clk;
            // rising link edges in this frame; cleared while deselected
            edges <= select_load_strobe_n ? 6'h00 : edges + 6'(serial_clk && !clk_q);
            // saturates so an idle link never wraps into the legal window
            age   <= (clk_q && !serial_clk) ? 4'h0 : age + 4'(age != 4'hf);
        end
    end
    sequence s_high_phase;
        serial_clk [*4] ##1 !serial_clk;
    endsequence
    sequence s_lead_in;
        !serial_clk [*3] ##[1:2] serial_clk;
    endsequence
    AST_CLK_IDLE: assert property (select_load_strobe_n |-> !serial_clk)
        else $error("link clock high while deselected");
    AST_HIGH_PHASE: assert property ($rose(serial_clk) |-> s_high_phase)
        else $error("link clock high phase wrong length");
    AST_LOW_PHASE: assert property ($fell(serial_clk) |-> !serial_clk [*4])
        else $error("link clock low phase too short");
    AST_FRAME_LEAD: assert property ($fell(select_load_strobe_n) |-> s_lead_in)
        else $error("frame lead-in wrong");
    AST_DATA_HOLD: assert property (serial_clk && clk_q |-> $stable(serial_word_in))
        else $error("data moved while link clock high");
    AST_FRAME_LEN: assert property ($rose(select_load_strobe_n) |->
        (edges == 6'h18 || edges == 6'h20))
        else $error("frame is neither 24 nor 32 bits");
    AST_STROBE_GAP: assert property ($rose(select_load_strobe_n) |->
        select_load_strobe_n [*3])
        else $error("strobe high gap too short");
    AST_CHAIN_TIME: assert property ($changed(serial_chain_out) |->
        age inside {[4'h1:4'h4]})
        else $error("chain output moved away from falling link edge");
endmodule

// ==== bench/serial_dac_command_interface_tb.sv ====
// bench: host and dac ends joined over the link, command table then corner cases
module serial_dac_command_interface_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic        upd;
        logic        lng;
        logic [3:0]  cmd;
        logic [15:0] data;
        logic [15:0] dac;
        logic [15:0] inp;
        logic        pd;
    } sdci_row_t;
    logic        sys_clk, rst_n, clr_n, upd_n, valid, lng, pd, rdy, ready, done;
    logic [3:0]  cmd;
    logic [15:0] data, dac_code, input_code;
    logic [31:0] chain_rx;
    int          num_errors, samples_checked;
    // 14-bit resolution, midscale reset: low two data bits read back as zero
    sdci_row_t   rows [11] = '{
        '{1'h1, 1'h0, 4'h0, 16'h1237, 16'h8000, 16'h1234, 1'h0},
        '{1'h1, 1'h1, 4'h1, 16'h0000, 16'h1234, 16'h1234, 1'h0},
        '{1'h1, 1'h0, 4'h4, 16'hffff, 16'h1234, 16'h1234, 1'h1},
        '{1'h1, 1'h1, 4'h2, 16'h5555, 16'h1234, 16'h1234, 1'h1},
        '{1'h1, 1'h0, 4'h3, 16'habcd, 16'habcc, 16'habcc, 1'h0},
        '{1'h1, 1'h0, 4'hf, 16'h0000, 16'habcc, 16'habcc, 1'h0},
        '{1'h1, 1'h0, 4'h0, 16'h4321, 16'habcc, 16'h4320, 1'h0},
        '{1'h0, 1'h0, 4'h4, 16'h0000, 16'h4320, 16'h4320, 1'h0},
        '{1'h1, 1'h1, 4'h7, 16'h9999, 16'h4320, 16'h4320, 1'h0},
        '{1'h1, 1'h0, 4'h4, 16'h0000, 16'h4320, 16'h4320, 1'h1},
        '{1'h1, 1'h0, 4'h1, 16'h0000, 16'h4320, 16'h4320, 1'h0}};
    sdci_link_if lk ();
    sdci_dac #(.MIDSCALE(1'b1), .RES_BITS(14), .PWRUP_CYC(8)) sdci_dac_i (
        .sys_clk_in(sys_clk), .rst_n_in(rst_n), .link(lk.dac), .async_clear_n_in(clr_n),
        .async_update_n_in(upd_n), .dac_code_out(dac_code), .input_code_out(input_code),
        .powered_down_out(pd), .output_ready_out(rdy));
    sdci_host sdci_host_i (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .link(lk.host),
        .req_valid_in(valid), .req_long_in(lng), .req_cmd_in(cmd), .req_data_in(data),
        .req_ready_out(ready), .chain_rx_out(chain_rx), .done_out(done));
    sdci_link_monitor sdci_link_monitor_i (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
        .serial_clk(lk.serial_clk), .serial_word_in(lk.serial_word_in),
        .select_load_strobe_n(lk.select_load_strobe_n), .serial_chain_out(lk.serial_chain_out));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    // the gap after done covers execution and the strobe-high spacing
    task automatic send(input logic l, input logic [3:0] c, input logic [15:0] d);
        repeat (200) begin
            if (ready === 1'b1) break;
            tick(1);
        end
        chk(32'(ready), 32'h1);
        {valid, lng, cmd, data} = {1'h1, l, c, d};
        tick(1);
        valid = 1'h0;
        repeat (2000) begin
            if (done === 1'b1) break;
            tick(1);
        end
        chk(32'(done), 32'h1);
        tick(6);
    endtask
    task automatic pin_pulse(input logic hold);
        tick(100);
        upd_n = 1'h0;
        if (!hold) begin
            tick(10);
            upd_n = 1'h1;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        sys_clk = 1'h0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (30000) @(posedge sys_clk);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        {rst_n, clr_n, upd_n, valid, lng} = 5'h0c;
        {cmd, data} = 20'h00000;
        tick(6);
        rst_n = 1'h1;
        chk({dac_code, input_code}, 32'h80008000);
        chk(32'({pd, rdy}), 32'h1);
        foreach (rows[i]) begin
            upd_n = rows[i].upd;
            tick(4);
            send(rows[i].lng, rows[i].cmd, rows[i].data);
            chk({dac_code, input_code}, {rows[i].dac, rows[i].inp});
            chk(32'(pd), 32'(rows[i].pd));
        end
        upd_n = 1'h1;
        send(1'h0, 4'h4, 16'h0000);
        chk(32'(rdy), 32'h0);
        send(1'h0, 4'h1, 16'h0000);
        chk(32'({pd, rdy}), 32'h0);
        tick(10);
        chk(32'(rdy), 32'h1);
        send(1'h0, 4'h4, 16'h0000);
        fork
            send(1'h0, 4'h0, 16'h3333);
            pin_pulse(1'h0);
        join
        chk({dac_code, input_code}, 32'h43203330);
        chk(32'(pd), 32'h0);
        fork
            send(1'h0, 4'hf, 16'h0000);
            pin_pulse(1'h1);
        join
        chk(32'(dac_code), 32'h3330);
        upd_n = 1'h1;
        send(1'h1, 4'hf, 16'h5a3c);
        send(1'h1, 4'hf, 16'h0000);
        chk({12'h000, chain_rx[23:20], chain_rx[15:0]}, 32'h000f5a3c);
        clr_n = 1'h0;
        tick(6);
        chk({dac_code, input_code}, 32'h80008000);
        clr_n = 1'h1;
        tick(4);
        tally_and_finish();
    end
endmodule
